// >>> common/fas_pkg.sv
// Purpose: constants and state type for the single-precision add/subtract datapath
// Assumes: main register holds sign, Q, P, characteristic 1-8 and fraction 9-35
// Notes: fraction bit 9 is index 26, bit 35 is index 0; characteristic bit 8 is index 0
package fas_pkg;
    localparam int CHAR_W = 8;
    localparam int MCHAR_W = 10;
    localparam int FRAC_W = 27;
    localparam int SC_W = 6;
    localparam int FRAC_MSB = 26;
    localparam int DIFF_BIG_HI = 7;
    localparam int DIFF_BIG_LO = 6;
    localparam logic [MCHAR_W-1:0] EXT_CHAR_OFFSET = 10'h01B;
    localparam logic [MCHAR_W-1:0] CHAR_ONE = 10'h001;
    localparam logic [MCHAR_W:0] ADD_CARRY_IN = 11'h001;
    localparam logic [FRAC_W-1:0] FRAC_ONE = 27'h0000001;

    typedef enum logic [3:0] {
        ST_IDLE, ST_LOAD, ST_CMP, ST_SWAP, ST_DIFF, ST_EQU, ST_ADD, ST_TSHIFT,
        ST_CFIX, ST_CMQ0, ST_CEXT1, ST_CEXT2, ST_NORM, ST_FIN, ST_ZERO
    } fas_state_t;
endpackage : fas_pkg

// >>> core/fas_core.sv
// Purpose: sequential single-precision floating add/subtract on main/extension/holding registers
// Assumes: sequencer holds start_i with operands stable until done_o
// Notes: cycle count depends on characteristic difference and normalization length
module fas_core
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic subtract_i,
    input wire logic normalize_i,
    input wire logic addr_sign_i,
    input wire logic [fas_pkg::CHAR_W-1:0] addr_char_i,
    input wire logic [fas_pkg::FRAC_W-1:0] addr_frac_i,
    input wire logic main_sign_i,
    input wire logic [fas_pkg::MCHAR_W-1:0] main_char_i,
    input wire logic [fas_pkg::FRAC_W-1:0] main_frac_i,
    output logic main_sign_o,
    output logic [fas_pkg::MCHAR_W-1:0] main_char_o,
    output logic [fas_pkg::FRAC_W-1:0] main_frac_o,
    output logic ext_sign_o,
    output logic [fas_pkg::CHAR_W-1:0] ext_char_o,
    output logic [fas_pkg::FRAC_W-1:0] ext_frac_o,
    output logic busy_o,
    output logic done_o
);
    import fas_pkg::*;

    fas_state_t state_ff, nxt_state;
    logic main_sign_ff, nxt_main_sign;
    logic [MCHAR_W-1:0] main_char_ff, nxt_main_char;
    logic [FRAC_W-1:0] main_frac_ff, nxt_main_frac;
    logic ext_sign_ff, nxt_ext_sign;
    logic [CHAR_W-1:0] ext_char_ff, nxt_ext_char;
    logic [FRAC_W-1:0] ext_frac_ff, nxt_ext_frac;
    logic hold_sign_ff, nxt_hold_sign;
    logic [CHAR_W-1:0] hold_char_ff, nxt_hold_char;
    logic [FRAC_W-1:0] hold_frac_ff, nxt_hold_frac;
    logic [SC_W-1:0] sc_ff, nxt_sc;
    logic norm_ff, nxt_norm;
    logic done_ff;
    logic busy_ff;

    // Characteristic adder: holding plus complemented main plus carry-in at position 8
    wire [MCHAR_W:0] char_sum = {3'b000, hold_char_ff} + {1'b0, ~main_char_ff} + ADD_CARRY_IN;
    wire q_carry = char_sum[MCHAR_W];
    wire diff_big = char_sum[DIFF_BIG_HI] | char_sum[DIFF_BIG_LO];
    wire like_signs = (hold_sign_ff == main_sign_ff);
    wire [FRAC_W:0] true_sum = {1'b0, hold_frac_ff} + {1'b0, main_frac_ff};
    wire [FRAC_W:0] comp_sum = {1'b0, hold_frac_ff} + {1'b0, ~main_frac_ff};
    wire [MCHAR_W-1:0] true_char = {2'b00, hold_char_ff} + {9'h000, true_sum[FRAC_W]};
    wire [MCHAR_W-1:0] dec_char = main_char_ff - CHAR_ONE;
    wire [MCHAR_W-1:0] ext_char_calc = main_char_ff - EXT_CHAR_OFFSET;
    wire main_zero = (main_frac_ff == '0);
    wire ext_zero = (ext_frac_ff == '0);
    wire both_zero = main_zero & ext_zero;
    wire norm_step = norm_ff & ~main_frac_ff[FRAC_MSB] & ~both_zero;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_main_sign = main_sign_ff;
        nxt_main_char = main_char_ff;
        nxt_main_frac = main_frac_ff;
        nxt_ext_sign = ext_sign_ff;
        nxt_ext_char = ext_char_ff;
        nxt_ext_frac = ext_frac_ff;
        nxt_hold_sign = hold_sign_ff;
        nxt_hold_char = hold_char_ff;
        nxt_hold_frac = hold_frac_ff;
        nxt_sc = sc_ff;
        nxt_norm = norm_ff;
        // One register transfer or one single-place shift per state
        case (state_ff)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    nxt_state = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                nxt_hold_sign = addr_sign_i ^ subtract_i;
                nxt_hold_char = addr_char_i;
                nxt_hold_frac = addr_frac_i;
                nxt_main_sign = main_sign_i;
                nxt_main_char = main_char_i;
                nxt_main_frac = main_frac_i;
                nxt_norm = normalize_i;
                nxt_state = ST_CMP;
            end
            ST_CMP:
            begin
                nxt_ext_sign = 1'b0;
                nxt_ext_char = '0;
                nxt_ext_frac = '0;
                nxt_state = q_carry ? ST_DIFF : ST_SWAP;
            end
            ST_SWAP:
            begin
                // Q and P are not kept: holding has no room and main gets them cleared
                nxt_hold_sign = main_sign_ff;
                nxt_main_sign = hold_sign_ff;
                nxt_hold_char = main_char_ff[CHAR_W-1:0];
                nxt_hold_frac = main_frac_ff;
                nxt_main_char = {2'b00, hold_char_ff};
                nxt_main_frac = hold_frac_ff;
                nxt_state = ST_DIFF;
            end
            ST_DIFF:
            begin
                if (diff_big)
                begin
                    nxt_main_char = '0;
                    nxt_main_frac = '0;
                    nxt_state = ST_ADD;
                end
                else
                begin
                    nxt_sc = char_sum[SC_W-1:0];
                    nxt_state = ST_EQU;
                end
            end
            ST_EQU:
            begin
                if (sc_ff == '0)
                begin
                    nxt_state = ST_ADD;
                end
                else
                begin
                    // Extension bit 35 falls off the end
                    nxt_ext_frac = {main_frac_ff[0], ext_frac_ff[FRAC_W-1:1]};
                    nxt_main_frac = {1'b0, main_frac_ff[FRAC_W-1:1]};
                    nxt_sc = sc_ff - 6'h01;
                end
            end
            ST_ADD:
            begin
                if (like_signs)
                begin
                    nxt_main_char = true_char;
                    nxt_main_frac = true_sum[FRAC_W-1:0];
                    nxt_state = true_sum[FRAC_W] ? ST_TSHIFT : ST_NORM;
                end
                else
                begin
                    nxt_main_char = {2'b00, hold_char_ff};
                    nxt_main_frac = comp_sum[FRAC_W-1:0];
                    if (!comp_sum[FRAC_W])
                    begin
                        nxt_state = ST_CFIX;
                    end
                    else
                    begin
                        nxt_main_sign = hold_sign_ff;
                        nxt_state = ext_zero ? ST_CMQ0 : ST_CEXT1;
                    end
                end
            end
            ST_TSHIFT:
            begin
                nxt_ext_frac = {main_frac_ff[0], ext_frac_ff[FRAC_W-1:1]};
                nxt_main_frac = {1'b1, main_frac_ff[FRAC_W-1:1]};
                nxt_state = ST_NORM;
            end
            ST_CFIX:
            begin
                nxt_main_frac = ~main_frac_ff;
                nxt_state = ST_NORM;
            end
            ST_CMQ0:
            begin
                nxt_main_frac = main_frac_ff + FRAC_ONE;
                nxt_state = ST_NORM;
            end
            ST_CEXT1:
            begin
                // Holding fraction is spent by now, so it serves as scratch
                nxt_hold_frac = ext_frac_ff;
                nxt_state = ST_CEXT2;
            end
            ST_CEXT2:
            begin
                nxt_ext_frac = ~hold_frac_ff + FRAC_ONE;
                nxt_state = ST_NORM;
            end
            ST_NORM:
            begin
                // A zero result never gains a leading one, so it must not loop
                if (norm_step)
                begin
                    nxt_main_frac = {main_frac_ff[FRAC_W-2:0], ext_frac_ff[FRAC_MSB]};
                    nxt_ext_frac = {ext_frac_ff[FRAC_W-2:0], 1'b0};
                    nxt_main_char = dec_char;
                end
                else
                begin
                    nxt_state = ST_FIN;
                end
            end
            ST_FIN:
            begin
                nxt_ext_char = ext_char_calc[CHAR_W-1:0];
                nxt_ext_sign = main_sign_ff;
                nxt_state = ST_ZERO;
            end
            ST_ZERO:
            begin
                if (both_zero && norm_ff)
                begin
                    nxt_main_char = '0;
                    nxt_main_frac = '0;
                    nxt_ext_char = '0;
                    nxt_ext_frac = '0;
                end
                nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_ff <= ST_IDLE;
            {main_sign_ff, main_char_ff, main_frac_ff} <= '0;
            {ext_sign_ff, ext_char_ff, ext_frac_ff} <= '0;
            {hold_sign_ff, hold_char_ff, hold_frac_ff} <= '0;
            sc_ff <= '0;
            norm_ff <= 1'b0;
            done_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            {main_sign_ff, main_char_ff, main_frac_ff} <= {nxt_main_sign, nxt_main_char, nxt_main_frac};
            {ext_sign_ff, ext_char_ff, ext_frac_ff} <= {nxt_ext_sign, nxt_ext_char, nxt_ext_frac};
            {hold_sign_ff, hold_char_ff, hold_frac_ff} <= {nxt_hold_sign, nxt_hold_char, nxt_hold_frac};
            sc_ff <= nxt_sc;
            norm_ff <= nxt_norm;
            done_ff <= (state_ff == ST_ZERO);
            // Registered from the next state so busy is a flop yet tracks the state exactly
            busy_ff <= (nxt_state != ST_IDLE);
        end
    end

    assign main_sign_o = main_sign_ff;
    assign main_char_o = main_char_ff;
    assign main_frac_o = main_frac_ff;
    assign ext_sign_o = ext_sign_ff;
    assign ext_char_o = ext_char_ff;
    assign ext_frac_o = ext_frac_ff;
    assign busy_o = busy_ff;
    assign done_o = done_ff;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_true_carry;
        state_ff == ST_ADD && like_signs && true_sum[FRAC_W];
    endsequence

    sequence s_comp_nocarry;
        state_ff == ST_ADD && !like_signs && !comp_sum[FRAC_W];
    endsequence

    sequence s_comp_carry;
        state_ff == ST_ADD && !like_signs && comp_sum[FRAC_W];
    endsequence

    sequence s_equ_step;
        state_ff == ST_EQU && sc_ff != '0;
    endsequence

    sequence s_norm_shift;
        state_ff == ST_NORM && norm_step;
    endsequence

    // A held start may launch the next operation right after done, so busy is checked only in the done cycle
    a_done_single: assert property (done_o |-> !busy_o ##1 !done_o)
        else $error("done held longer than one cycle");
    a_sub_sign: assert property (state_ff == ST_LOAD |=> hold_sign_ff == $past(addr_sign_i ^ subtract_i))
        else $error("holding sign not inverted for subtraction");
    a_swap_cause: assert property (state_ff == ST_CMP && !q_carry |=> state_ff == ST_SWAP ##1 main_char_ff[MCHAR_W-1:CHAR_W] == 2'b00)
        else $error("interchange missing or Q/P kept");
    a_big_clear: assert property (state_ff == ST_DIFF && diff_big |=> main_char_ff == '0 && main_frac_ff == '0 && state_ff == ST_ADD)
        else $error("large difference did not clear main");
    a_equ_count: assert property (state_ff == ST_EQU && sc_ff != '0 |=> sc_ff == $past(sc_ff) - 6'h01 && !main_frac_ff[FRAC_MSB])
        else $error("equalize step wrong");
    a_true_shift: assert property (s_true_carry |=> state_ff == ST_TSHIFT ##1 main_frac_ff[FRAC_MSB] && state_ff == ST_NORM)
        else $error("true-add carry not shifted in");
    a_comp_fix: assert property (s_comp_nocarry ##1 state_ff == ST_CFIX |=> main_frac_ff == ~$past(main_frac_ff))
        else $error("main fraction not recomplemented");
    a_ext_char: assert property (state_ff == ST_FIN |=> ext_char_o == $past(ext_char_calc[CHAR_W-1:0]) && ext_sign_o == main_sign_o)
        else $error("extension characteristic or sign wrong");
    a_norm_first: assert property (state_ff == ST_FIN && norm_ff && !both_zero |-> main_frac_ff[FRAC_MSB])
        else $error("derived extension characteristic before normalizing");
    a_zero_clear: assert property (state_ff == ST_ZERO && both_zero && norm_ff |=> main_char_o == '0 && ext_char_o == '0 && done_o)
        else $error("zero result not cleared");

    // Step-level checks of the add paths, the shift loops and the other sequencer steps
    a_like_add: assert property (state_ff == ST_ADD && like_signs |=> main_frac_ff == $past(true_sum[FRAC_W-1:0]))
        else $error("true addition sum wrong");
    a_unlike_add: assert property (state_ff == ST_ADD && !like_signs |=> main_frac_ff == $past(comp_sum[FRAC_W-1:0]))
        else $error("complement addition sum wrong");
    a_comp_sign: assert property (s_comp_carry |=> main_sign_ff == $past(hold_sign_ff))
        else $error("holding sign not copied on carry");
    a_carry_route: assert property (s_comp_carry |=> state_ff == ($past(ext_zero) ? ST_CMQ0 : ST_CEXT1))
        else $error("complement carry routed wrong");
    a_carry_main: assert property (state_ff == ST_CMQ0 |=> main_frac_ff == $past(main_frac_ff) + FRAC_ONE)
        else $error("carry not added at main bit 35");
    a_ext_comp: assert property (state_ff == ST_CEXT2 |=> ext_frac_ff == ~$past(hold_frac_ff) + FRAC_ONE)
        else $error("extension fraction not complemented");
    a_norm_step: assert property (s_norm_shift |=> main_char_ff == $past(dec_char) && !ext_frac_ff[0])
        else $error("normalize step wrong");
    a_ext_clear: assert property (state_ff == ST_CMP |=> ext_frac_ff == '0 && ext_char_ff == '0)
        else $error("extension not cleared at compare");
    a_ext_discard: assert property (s_equ_step
        |=> ext_frac_ff == {$past(main_frac_ff[0]), $past(ext_frac_ff[FRAC_W-1:1])})
        else $error("equalize shift into extension wrong");
    a_one_shift: assert property (s_equ_step |=> state_ff == ST_EQU)
        else $error("equalize left loop early");
    a_busy_take: assert property (state_ff == ST_IDLE && start_i |=> busy_o)
        else $error("start not taken");
    a_ext_sign: assert property (state_ff == ST_FIN |=> ext_sign_o == $past(main_sign_ff))
        else $error("extension sign not copied");
    a_diff_load: assert property (state_ff == ST_DIFF && !diff_big |=> sc_ff == $past(char_sum[SC_W-1:0]))
        else $error("shift counter not loaded");
    a_swap_frac: assert property (state_ff == ST_SWAP
        |=> hold_frac_ff == $past(main_frac_ff) && main_frac_ff == $past(hold_frac_ff))
        else $error("fractions not interchanged");
    a_zero_done: assert property (state_ff == ST_ZERO |=> done_o && !busy_o)
        else $error("done missing after zero check");
    // Results must stand between operations for the sequencer to read them
    a_idle_hold: assert property (state_ff == ST_IDLE && !start_i |=> $stable(main_frac_ff) && $stable(ext_frac_ff))
        else $error("results changed while idle");
endmodule : fas_core

// >>> tb/fas_core_bench.sv
// Purpose: self-checking bench for the add/subtract datapath
// Assumes: expected results come from a bench-side model of the add sequence
// Notes: operands travel as one vector {sub, norm, sign, char, frac, sign, char, frac}
`define CHK(nm, ex, got) \
    begin checks++; if ((ex) !== (got)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end
module fas_core_bench;
    import fas_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, srst_i, go, start_w, sub_w, norm_w, as_w, ms_w;
    logic [75:0] op_req, op_w;
    logic [7:0] ac_w, e_ec, ext_char_o;
    logic [9:0] mc_w, e_mc, main_char_o;
    logic [26:0] af_w, mf_w, e_mf, e_ef, main_frac_o, ext_frac_o;
    logic e_ms, e_es, main_sign_o, ext_sign_o, busy_o, done_o;
    int checks = 0;
    int n_mismatch = 0;
    assign {sub_w, norm_w, as_w, ac_w, af_w, ms_w, mc_w, mf_w} = op_w;

    fas_seq_model seq (.clock_i(clock_i), .go_i(go), .op_i(op_req), .done_i(done_o),
        .start_o(start_w), .op_o(op_w));
    fas_core dut (.clock_i(clock_i), .srst_i(srst_i), .start_i(start_w), .subtract_i(sub_w),
        .normalize_i(norm_w), .addr_sign_i(as_w), .addr_char_i(ac_w), .addr_frac_i(af_w),
        .main_sign_i(ms_w), .main_char_i(mc_w), .main_frac_i(mf_w),
        .main_sign_o(main_sign_o), .main_char_o(main_char_o), .main_frac_o(main_frac_o),
        .ext_sign_o(ext_sign_o), .ext_char_o(ext_char_o), .ext_frac_o(ext_frac_o),
        .busy_o(busy_o), .done_o(done_o));

    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    task automatic ref_op(input logic [75:0] v);
        logic sb, nm, hs, ms;
        logic [9:0] hc, mc;
        logic [26:0] hf, mf, ef;
        logic [27:0] s;
        int d;
        {sb, nm, hs, hc[7:0], hf, ms, mc, mf} = v;
        hc[9:8] = 2'b00;
        hs = hs ^ sb;
        ef = 27'h0;
        if (mc > hc)
        begin
            {hs, ms} = {ms, hs};
            {hc, hf, mc, mf} = {2'b00, mc[7:0], mf, 2'b00, hc[7:0], hf};
        end
        d = hc[7:0] - mc[7:0];
        if (d >= 64)
            mf = 27'h0;
        else
            {mf, ef} = {mf, ef} >> d;
        mc = hc;
        if (hs == ms)
        begin
            s = hf + mf;
            if (s[27])
            begin
                mc = hc + 10'h001;
                {mf, ef} = {1'b1, s[26:0], ef} >> 1;
            end
            else
                mf = s[26:0];
        end
        else
        begin
            s = hf + {1'b0, ~mf};
            if (!s[27])
                mf = ~s[26:0];
            else
            begin
                ms = hs;
                if (ef == 27'h0)
                    mf = s[26:0] + 27'h1;
                else
                begin
                    mf = s[26:0];
                    ef = ~ef + 27'h1;
                end
            end
        end
        if (nm && {mf, ef} != 54'h0)
            while (!mf[26])
            begin
                {mf, ef} = {mf, ef} << 1;
                mc = mc - 10'h001;
            end
        {e_ms, e_mc, e_mf, e_es, e_ef} = {ms, mc, mf, ms, ef};
        e_ec = mc[7:0] - 8'h1B;
        if (nm && {mf, ef} == 54'h0)
            {e_mc, e_mf, e_ec, e_ef} = '0;
    endtask : ref_op

    // Waits out the whole run because cycle count depends on the operands
    task automatic run_op(input logic [75:0] v);
        int n;
        ref_op(v);
        op_req <= v;
        go <= 1'b1;
        n = 0;
        while (done_o !== 1'b1 && n < 400)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 400)
        begin
            n_mismatch++;
            wrap_up();
        end
        `CHK("busy at done", 1'b0, busy_o)
        `CHK("main sign", e_ms, main_sign_o)
        `CHK("main char", e_mc, main_char_o)
        `CHK("main frac", e_mf, main_frac_o)
        `CHK("ext sign", e_es, ext_sign_o)
        `CHK("ext char", e_ec, ext_char_o)
        `CHK("ext frac", e_ef, ext_frac_o)
        go <= 1'b0;
        @(negedge clock_i);
        `CHK("done pulse", 1'b0, done_o)
        `CHK("result held", e_mf, main_frac_o)
    endtask : run_op

    task automatic s_reset;
        `CHK("busy in reset", 1'b0, busy_o)
        `CHK("done in reset", 1'b0, done_o)
        `CHK("ext char in reset", 8'h00, ext_char_o)
    endtask : s_reset

    task automatic s_true_carry;
        run_op({1'b0, 1'b1, 1'b0, 8'h81, 27'h6000000, 1'b0, 10'h080, 27'h4000001});
    endtask : s_true_carry

    task automatic s_sub_no_carry;
        run_op({1'b1, 1'b1, 1'b1, 8'h80, 27'h1000000, 1'b1, 10'h080, 27'h2000000});
    endtask : s_sub_no_carry

    task automatic s_swap_carry;
        run_op({1'b0, 1'b0, 1'b0, 8'h80, 27'h4000000, 1'b1, 10'h082, 27'h4000000});
    endtask : s_swap_carry

    task automatic s_ext_carry;
        run_op({1'b0, 1'b0, 1'b0, 8'h84, 27'h4000000, 1'b1, 10'h080, 27'h0000003});
    endtask : s_ext_carry

    task automatic s_far_apart;
        run_op({1'b0, 1'b1, 1'b0, 8'hC0, 27'h5000000, 1'b0, 10'h040, 27'h7FFFFFF});
    endtask : s_far_apart

    task automatic s_qp_swap;
        run_op({1'b0, 1'b1, 1'b0, 8'h80, 27'h4000000, 1'b0, 10'h281, 27'h4000000});
    endtask : s_qp_swap

    task automatic s_no_norm;
        run_op({1'b0, 1'b0, 1'b0, 8'h80, 27'h0100000, 1'b0, 10'h080, 27'h0010000});
    endtask : s_no_norm

    task automatic s_zero;
        run_op({1'b0, 1'b1, 1'b0, 8'h80, 27'h0000000, 1'b1, 10'h080, 27'h0000000});
    endtask : s_zero

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial
    begin
        srst_i = 1'b1;
        go = 1'b0;
        op_req = 76'h0;
        repeat (4) @(negedge clock_i);
        s_reset();
        srst_i = 1'b0;
        @(negedge clock_i);
        s_true_carry();
        s_sub_no_carry();
        s_swap_carry();
        s_ext_carry();
        s_far_apart();
        s_qp_swap();
        s_no_norm();
        s_zero();
        wrap_up();
    end
endmodule : fas_core_bench

// >>> tb/fas_seq_model.sv
// Purpose: sequencer stand-in that raises start with operands and holds them until done
// Assumes: bench raises go_i at a falling edge and keeps it up until done is seen
// Notes: released operand lines flip to inverted values so stale data never looks valid
module fas_seq_model
(
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic [75:0] op_i,
    input wire logic done_i,
    output logic start_o,
    output logic [75:0] op_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        start_o = 1'b0;
        op_o = 76'h0;
    end

    always @(negedge clock_i)
    begin
        if (!start_o && go_i)
        begin
            start_o <= 1'b1;
            op_o <= op_i;
        end
        else if (start_o && done_i)
        begin
            start_o <= 1'b0;
            op_o <= ~op_o;
        end
    end
endmodule : fas_seq_model
